// ---- rtl/tc8_pkg.sv ----
// shared constants and types of the 8-bit timer/counter unit
package tc8_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned TC8_AW = 3;
  localparam logic [TC8_AW-1:0] TC8_ADDR_CTRL  = 3'h0;
  localparam logic [TC8_AW-1:0] TC8_ADDR_COUNT = 3'h1;
  localparam logic [TC8_AW-1:0] TC8_ADDR_CMP   = 3'h2;
  localparam logic [TC8_AW-1:0] TC8_ADDR_FLAG  = 3'h3;
  localparam logic [TC8_AW-1:0] TC8_ADDR_MASK  = 3'h4;

  // flag and mask bit positions
  localparam int unsigned TC8_BIT_OVF = 0;
  localparam int unsigned TC8_BIT_CMP = 1;

  // ----------------------------------------------------------------
  // counter values
  // ----------------------------------------------------------------
  localparam logic [7:0] TC8_BOTTOM    = 8'h00;
  localparam logic [7:0] TC8_MAX       = 8'hff;
  localparam logic [7:0] TC8_ONE       = 8'h01;
  localparam logic [7:0] TC8_RST_COUNT = 8'h00;
  localparam logic [7:0] TC8_RST_CMP   = 8'h00;

  // ----------------------------------------------------------------
  // modes and selections
  // ----------------------------------------------------------------
  localparam logic [1:0] TC8_WGM_NORMAL = 2'h0;
  localparam logic [1:0] TC8_WGM_PHASE  = 2'h1;
  localparam logic [1:0] TC8_WGM_CTC    = 2'h2;
  localparam logic [1:0] TC8_WGM_FAST   = 2'h3;

  localparam logic [1:0] TC8_COM_OFF    = 2'h0;
  localparam logic [1:0] TC8_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TC8_COM_CLEAR  = 2'h2;
  localparam logic [1:0] TC8_COM_SET    = 2'h3;

  localparam logic [2:0] TC8_CS_STOP  = 3'h0;
  localparam logic [2:0] TC8_CS_DIV1  = 3'h1;
  localparam logic [2:0] TC8_CS_DIV8  = 3'h2;
  localparam logic [2:0] TC8_CS_DIV64 = 3'h3;
  localparam logic [2:0] TC8_CS_DIV256  = 3'h4;
  localparam logic [2:0] TC8_CS_DIV1024 = 3'h5;
  localparam logic [2:0] TC8_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TC8_CS_EXT_RISE = 3'h7;

  // prescaler taps: a tick when all masked bits are ones
  localparam int unsigned TC8_PRE_W = 10;
  localparam logic [9:0] TC8_MASK_DIV8    = 10'h007;
  localparam logic [9:0] TC8_MASK_DIV64   = 10'h03f;
  localparam logic [9:0] TC8_MASK_DIV256  = 10'h0ff;
  localparam logic [9:0] TC8_MASK_DIV1024 = 10'h3ff;

  // ----------------------------------------------------------------
  // control register layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       spare;
    logic [1:0] com;
    logic [1:0] wgm;
    logic [2:0] cs;
  } tc8_ctrl_s;

  localparam tc8_ctrl_s TC8_RST_CTRL = '{spare: 1'b0, com: TC8_COM_OFF, wgm: TC8_WGM_NORMAL, cs: TC8_CS_STOP};

  typedef struct packed {
    logic cmp;
    logic ovf;
  } tc8_flags_s;

endpackage : tc8_pkg

// ---- rtl/tc8_tick_gen.sv ----
// clock select and prescaler producing single-cycle timer ticks
`timescale 1ns/10ps
module tc8_tick_gen
  import tc8_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [2:0] clock_select_field,
  input  wire logic       external_count_pin,
  output logic            timer_tick
);

  // ----------------------------------------------------------------
  // prescaler and pin synchroniser
  // ----------------------------------------------------------------
  logic [TC8_PRE_W-1:0] pre_r;
  logic                 pin_s1_r;
  logic                 pin_s2_r;
  logic                 pin_s3_r;
  logic                 tick_r;

  // prescaler is free running so a source switch never waits a full wrap
  always_ff @(posedge clock) begin
    if (reset) begin
      pre_r    <= '0;
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
    end else begin
      pre_r    <= pre_r + 10'h001;
      pin_s1_r <= external_count_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // source and edge selection
  // ----------------------------------------------------------------
  wire rise_w = pin_s2_r & ~pin_s3_r;
  wire fall_w = ~pin_s2_r & pin_s3_r;
  logic tick_nxt;

  always_comb begin
    unique case (clock_select_field)
      TC8_CS_STOP:     tick_nxt = 1'b0;
      TC8_CS_DIV1:     tick_nxt = 1'b1;
      TC8_CS_DIV8:     tick_nxt = &(pre_r | ~TC8_MASK_DIV8);
      TC8_CS_DIV64:    tick_nxt = &(pre_r | ~TC8_MASK_DIV64);
      TC8_CS_DIV256:   tick_nxt = &(pre_r | ~TC8_MASK_DIV256);
      TC8_CS_DIV1024:  tick_nxt = &(pre_r | ~TC8_MASK_DIV1024);
      TC8_CS_EXT_FALL: tick_nxt = fall_w;
      TC8_CS_EXT_RISE: tick_nxt = rise_w;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= tick_nxt;
    end
  end

  assign timer_tick = tick_r;

endmodule : tc8_tick_gen

// ---- rtl/tc8_wavegen.sv ----
// waveform generator driving the compare output pin
`timescale 1ns/10ps
module tc8_wavegen
  import tc8_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [1:0] waveform_mode_field,
  input  wire logic [1:0] com,
  input  wire logic       match_event,
  input  wire logic       wrap_event,
  input  wire logic       counting_down,
  output logic            compare_output_pin
);

  logic oc_r;
  logic oc_nxt;

  wire pwm_w  = (waveform_mode_field == TC8_WGM_FAST) | (waveform_mode_field == TC8_WGM_PHASE);
  wire inv_w  = (com == TC8_COM_SET);
  wire pwm_on = pwm_w & (com[1]);

  // toggle mode is only meaningful outside the pwm modes
  always_comb begin
    oc_nxt = oc_r;
    if (com != TC8_COM_OFF) begin
      if (!pwm_w && match_event) begin
        unique case (com)
          TC8_COM_TOGGLE: oc_nxt = ~oc_r;
          TC8_COM_CLEAR:  oc_nxt = 1'b0;
          TC8_COM_SET:    oc_nxt = 1'b1;
          default:        oc_nxt = oc_r;
        endcase
      end else if (pwm_on && waveform_mode_field == TC8_WGM_FAST) begin
        if (match_event) begin
          oc_nxt = inv_w;
        end else if (wrap_event) begin
          oc_nxt = ~inv_w;
        end
      end else if (pwm_on && match_event) begin
        oc_nxt = counting_down ? ~inv_w : inv_w;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      oc_r <= 1'b0;
    end else begin
      oc_r <= oc_nxt;
    end
  end

  assign compare_output_pin = oc_r;

endmodule : tc8_wavegen

// ---- rtl/tc8_timer.sv ----
// top of the 8-bit timer/counter unit with its register port
`timescale 1ns/10ps

// ----------------------------------------------------------------
// top module
// ----------------------------------------------------------------
module tc8_timer
  import tc8_pkg::*;
#(
  parameter int unsigned DATA_W = 8
) (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic [TC8_AW-1:0] address,
  input  wire logic [DATA_W-1:0] write_data,
  input  wire logic              write_strobe,
  input  wire logic              read_strobe,
  output logic      [DATA_W-1:0] read_data,
  input  wire logic              external_count_pin,
  output logic                   compare_output_pin,
  output logic                   overflow_request,
  output logic                   compare_request,
  output logic                   bottom,
  output logic                   at_max
);

  // only the documented width is served
  if (DATA_W != 8) begin : g_bad_width
    $error("tc8_timer: DATA_W must be 8");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tc8_ctrl_s  ctrl_r;
  tc8_flags_s flags_r;
  tc8_flags_s mask_r;
  logic [7:0] counter_value_r;
  logic [7:0] compare_buf_r;
  logic [7:0] compare_act_r;
  logic       down_r;
  logic       block_r;
  logic [7:0] rdata_r;
  logic       timer_tick;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire ctrl_we  = write_strobe & (address == TC8_ADDR_CTRL);
  wire cnt_we   = write_strobe & (address == TC8_ADDR_COUNT);
  wire cmp_we   = write_strobe & (address == TC8_ADDR_CMP);
  wire flag_we  = write_strobe & (address == TC8_ADDR_FLAG);
  wire mask_we  = write_strobe & (address == TC8_ADDR_MASK);

  // ----------------------------------------------------------------
  // tick source
  // ----------------------------------------------------------------
  tc8_tick_gen u_tick (
    .clock              (clock),
    .reset              (reset),
    .clock_select_field (ctrl_r.cs),
    .external_count_pin (external_count_pin),
    .timer_tick         (timer_tick)
  );

  // ----------------------------------------------------------------
  // counter decisions
  // ----------------------------------------------------------------
  wire       mode_phase = (ctrl_r.wgm == TC8_WGM_PHASE);
  wire       mode_ctc   = (ctrl_r.wgm == TC8_WGM_CTC);
  wire       mode_fast  = (ctrl_r.wgm == TC8_WGM_FAST);
  wire       is_bottom  = (counter_value_r == TC8_BOTTOM);
  wire       is_max     = (counter_value_r == TC8_MAX);
  wire [7:0] top_value  = mode_ctc ? compare_act_r : TC8_MAX;
  wire       is_top     = (counter_value_r == top_value);
  wire       match      = (counter_value_r == compare_act_r);
  wire       match_evt  = timer_tick & match & ~block_r;
  wire       wrap_evt   = timer_tick & is_max & ~mode_phase;
  wire       ovf_evt    = mode_phase ? (timer_tick & is_bottom & down_r) : wrap_evt;
  wire       turn_down  = mode_phase & ~down_r & is_top;
  wire       turn_up    = mode_phase & down_r & is_bottom;
  wire       step_down  = (down_r & ~turn_up) | turn_down;
  wire       ctc_clear  = mode_ctc & is_top;
  wire       buf_load   = mode_phase | mode_fast ? (timer_tick & is_top) : 1'b1;

  logic [7:0] counter_nxt;
  logic       down_nxt;

  always_comb begin
    counter_nxt = counter_value_r;
    down_nxt    = mode_phase ? down_r : 1'b0;
    if (cnt_we) begin
      counter_nxt = write_data[7:0];
    end else if (timer_tick) begin
      if (ctc_clear) begin
        counter_nxt = TC8_BOTTOM;
      end else if (step_down) begin
        counter_nxt = counter_value_r - TC8_ONE;
      end else begin
        counter_nxt = counter_value_r + TC8_ONE;
      end
    end
    if (timer_tick && (turn_down || turn_up)) begin
      down_nxt = turn_down;
    end
  end

  // ----------------------------------------------------------------
  // counter, compare and block registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      counter_value_r <= TC8_RST_COUNT;
      down_r          <= 1'b0;
    end else begin
      counter_value_r <= counter_nxt;
      down_r          <= down_nxt;
    end
  end

  // non-pwm modes pass software writes straight through
  always_ff @(posedge clock) begin
    if (reset) begin
      compare_buf_r <= TC8_RST_CMP;
      compare_act_r <= TC8_RST_CMP;
    end else begin
      if (cmp_we) begin
        compare_buf_r <= write_data[7:0];
      end
      if (buf_load) begin
        compare_act_r <= cmp_we ? write_data[7:0] : compare_buf_r;
      end
    end
  end

  // block holds across a stopped timer until the next tick
  always_ff @(posedge clock) begin
    if (reset) begin
      block_r <= 1'b0;
    end else if (cnt_we) begin
      block_r <= 1'b1;
    end else if (timer_tick) begin
      block_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control, flags and mask
  // ----------------------------------------------------------------
  tc8_flags_s set_w;
  tc8_flags_s clr_w;
  assign set_w.ovf = ovf_evt;
  assign set_w.cmp = match_evt;
  assign clr_w.ovf = flag_we & write_data[TC8_BIT_OVF];
  assign clr_w.cmp = flag_we & write_data[TC8_BIT_CMP];

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_r  <= TC8_RST_CTRL;
      flags_r <= '0;
      mask_r  <= '0;
    end else begin
      if (ctrl_we) begin
        ctrl_r <= tc8_ctrl_s'(write_data[7:0]);
      end
      if (mask_we) begin
        mask_r <= tc8_flags_s'(write_data[TC8_BIT_CMP:TC8_BIT_OVF]);
      end
      // a set in the clearing cycle wins
      flags_r <= set_w | (flags_r & ~clr_w);
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  wire [7:0] rd_mux =
    (address == TC8_ADDR_CTRL)  ? 8'(ctrl_r)          :
    (address == TC8_ADDR_COUNT) ? counter_value_r     :
    (address == TC8_ADDR_CMP)   ? compare_buf_r       :
    (address == TC8_ADDR_FLAG)  ? {6'h00, flags_r}    :
    (address == TC8_ADDR_MASK)  ? {6'h00, mask_r}     : 8'h00;

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= read_strobe ? rd_mux : 8'h00;
    end
  end

  assign read_data        = rdata_r;
  assign overflow_request = flags_r.ovf & mask_r.ovf;
  assign compare_request  = flags_r.cmp & mask_r.cmp;
  assign bottom           = is_bottom;
  assign at_max           = is_max;

  // ----------------------------------------------------------------
  // waveform generator
  // ----------------------------------------------------------------
  tc8_wavegen u_wave (
    .clock               (clock),
    .reset               (reset),
    .waveform_mode_field (ctrl_r.wgm),
    .com                 (ctrl_r.com),
    .match_event         (match_evt),
    .wrap_event          (wrap_evt),
    .counting_down       (down_r),
    .compare_output_pin  (compare_output_pin)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_stop_no_tick: assert property (@(posedge clock) disable iff (reset)
    (ctrl_r.cs == TC8_CS_STOP) && ($past(ctrl_r.cs) == TC8_CS_STOP) |-> !timer_tick)
    else $error("tick while stopped");

  a_write_wins: assert property (@(posedge clock) disable iff (reset)
    cnt_we |=> counter_value_r == $past(write_data[7:0]))
    else $error("counter write lost");

  a_idle_hold: assert property (@(posedge clock) disable iff (reset)
    !timer_tick && !cnt_we |=> $stable(counter_value_r))
    else $error("counter moved without tick");

  a_normal_step: assert property (@(posedge clock) disable iff (reset)
    timer_tick && !cnt_we && ctrl_r.wgm == TC8_WGM_NORMAL
      |=> counter_value_r == $past(counter_value_r) + TC8_ONE)
    else $error("normal step wrong");

  a_normal_ovf: assert property (@(posedge clock) disable iff (reset)
    timer_tick && ctrl_r.wgm == TC8_WGM_NORMAL && is_max && !cnt_we
      |=> flags_r.ovf && counter_value_r == TC8_BOTTOM)
    else $error("overflow not set at wrap");

  a_ctc_clear: assert property (@(posedge clock) disable iff (reset)
    timer_tick && !cnt_we && mode_ctc && match |=> counter_value_r == TC8_BOTTOM)
    else $error("ctc did not clear");

  a_match_flag: assert property (@(posedge clock) disable iff (reset)
    timer_tick && match && !block_r |=> flags_r.cmp)
    else $error("match flag not set");

  a_block_match: assert property (@(posedge clock) disable iff (reset)
    block_r && !flags_r.cmp |=> !flags_r.cmp)
    else $error("match not blocked");

  a_buffer_hold: assert property (@(posedge clock) disable iff (reset)
    mode_fast && !ctrl_we && !(timer_tick && is_max) |=> $stable(compare_act_r))
    else $error("compare updated off top");

  a_cmp_direct: assert property (@(posedge clock) disable iff (reset)
    cmp_we && !(mode_phase || mode_fast) |=> compare_act_r == $past(write_data[7:0]))
    else $error("compare not passed through");

  a_phase_ovf: assert property (@(posedge clock) disable iff (reset)
    timer_tick && mode_phase && down_r && is_bottom |=> flags_r.ovf)
    else $error("phase overflow missing");

  a_phase_up_quiet: assert property (@(posedge clock) disable iff (reset)
    mode_phase && !down_r && !flags_r.ovf |=> !flags_r.ovf)
    else $error("phase overflow while counting up");

  a_phase_turn: assert property (@(posedge clock) disable iff (reset)
    timer_tick && !cnt_we && mode_phase && !down_r && is_max
      |=> down_r && counter_value_r == TC8_MAX - TC8_ONE)
    else $error("phase did not turn at top");

  a_flag_clear: assert property (@(posedge clock) disable iff (reset)
    flag_we && write_data[TC8_BIT_CMP] && !match_evt |=> !flags_r.cmp)
    else $error("compare flag not cleared");

  a_tick_step: assert property (@(posedge clock) disable iff (reset)
    timer_tick && !cnt_we
      |=> (counter_value_r == $past(counter_value_r) + TC8_ONE)
       || (counter_value_r == $past(counter_value_r) - TC8_ONE)
       || (counter_value_r == TC8_BOTTOM))
    else $error("tick moved counter by more than one");

  a_read_idle: assert property (@(posedge clock) disable iff (reset)
    !read_strobe |=> read_data == 8'h00)
    else $error("read data outside its cycle");

  c_ovf_wrap: cover property (@(posedge clock) disable iff (reset) ovf_evt);
  c_ctc_clear: cover property (@(posedge clock) disable iff (reset) timer_tick && ctc_clear);
  c_phase_turn: cover property (@(posedge clock) disable iff (reset) timer_tick && turn_down);
  c_blocked: cover property (@(posedge clock) disable iff (reset) block_r && timer_tick && match);
  c_fast_load: cover property (@(posedge clock) disable iff (reset) mode_fast && buf_load);

endmodule : tc8_timer

// ---- dv/tb.sv ----
// self-checking testbench of the 8-bit timer/counter unit
`timescale 1ns/10ps
module tb
  import tc8_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic              clock;
  logic              reset;
  logic [TC8_AW-1:0] address;
  logic [7:0]        write_data;
  logic              write_strobe;
  logic              read_strobe;
  logic [7:0]        read_data;
  logic              external_count_pin;
  logic              compare_output_pin;
  logic              overflow_request;
  logic              compare_request;
  logic              bottom;
  logic              at_max;
  int                err_total;
  int                checks_done;
  int                cycles;
  logic [7:0]        seen;

  tc8_timer #(.DATA_W(8)) tc8_timer_inst (
    .clock              (clock),
    .reset              (reset),
    .address            (address),
    .write_data         (write_data),
    .write_strobe       (write_strobe),
    .read_strobe        (read_strobe),
    .read_data          (read_data),
    .external_count_pin (external_count_pin),
    .compare_output_pin (compare_output_pin),
    .overflow_request   (overflow_request),
    .compare_request    (compare_request),
    .bottom             (bottom),
    .at_max             (at_max)
  );

  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ceiling well above the roughly 2000 cycles the sequence needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] ctl(input logic [1:0] com, input logic [1:0] wgm, input logic [2:0] cs);
    ctl = {1'b0, com, wgm, cs};
  endfunction : ctl

  task automatic wr(input logic [TC8_AW-1:0] a, input logic [7:0] d);
    @(posedge clock);
    address      <= a;
    write_data   <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
    // let the write settle before any level check follows
    #1;
  endtask : wr

  task automatic rd(input logic [TC8_AW-1:0] a, output logic [7:0] d);
    @(posedge clock);
    address     <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 d = read_data;
  endtask : rd

  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk8

  task automatic chk1(input string name, input logic exp, input logic got);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask : chk1

  // within a window where prescaler phase leaves a small spread
  task automatic chkr(input string name, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] got);
    checks_done = checks_done + 1;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      err_total = err_total + 1;
      $display("[ERR] %s expected %h..%h seen %h", name, lo, hi, got);
    end
  endtask : chkr

  task automatic rdchk(input logic [TC8_AW-1:0] a, input logic [7:0] exp, input string name);
    rd(a, seen);
    chk8(name, exp, seen);
  endtask : rdchk

  // n full pin pulses; each long enough for the synchroniser to see both edges
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clock);
      external_count_pin <= 1'b1;
      repeat (8) @(posedge clock);
      external_count_pin <= 1'b0;
      repeat (8) @(posedge clock);
    end
  endtask : pulse

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    err_total = 0;
    checks_done = 0;
    cycles = 0;
    reset = 1'b1;
    address = '0;
    write_data = '0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    external_count_pin = 1'b0;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    // reset state and unmapped places
    for (int i = 0; i < 8; i++) rdchk(i[TC8_AW-1:0], 8'h00, "reset read");
    chk1("bottom", 1'b1, bottom);
    chk1("at_max", 1'b0, at_max);
    chk1("cmp pin", 1'b0, compare_output_pin);
    // full 8-bit counter and compare values, stopped counter holds
    wr(TC8_ADDR_COUNT, 8'hff);
    chk1("at_max", 1'b1, at_max);
    chk1("bottom", 1'b0, bottom);
    wr(TC8_ADDR_CMP, 8'ha5);
    rdchk(TC8_ADDR_CMP, 8'ha5, "compare");
    wr(TC8_ADDR_COUNT, 8'h5a);
    repeat (40) @(posedge clock);
    rdchk(TC8_ADDR_COUNT, 8'h5a, "stopped count");
    // every mode readable in the control register, with the source held at stop
    for (int m = 0; m < 4; m++) begin
      wr(TC8_ADDR_CTRL, ctl(TC8_COM_OFF, m[1:0], TC8_CS_STOP));
      rdchk(TC8_ADDR_CTRL, ctl(TC8_COM_OFF, m[1:0], TC8_CS_STOP), "control");
    end
    // prescaled sources: 200 cycles of running give about 200/div ticks
    for (int s = 1; s < 6; s++) begin
      wr(TC8_ADDR_COUNT, 8'h00);
      wr(TC8_ADDR_CTRL, ctl(TC8_COM_OFF, TC8_WGM_NORMAL, s[2:0]));
      repeat (198) @(posedge clock);
      wr(TC8_ADDR_CTRL, ctl(TC8_COM_OFF, TC8_WGM_NORMAL, TC8_CS_STOP));
      rd(TC8_ADDR_COUNT, seen);
      case (s)
        1: chkr("div1", 8'd197, 8'd203, seen);
        2: chkr("div8", 8'd23, 8'd27, seen);
        3: chkr("div64", 8'd2, 8'd4, seen);
        default: chkr("slow div", 8'd0, 8'd1, seen);
      endcase
    end
    // write wins over counting while running from the clock
    wr(TC8_ADDR_FLAG, 8'h03);
    wr(TC8_ADDR_COUNT, 8'h80);
    wr(TC8_ADDR_CTRL, ctl(TC8_COM_OFF, TC8_WGM_NORMAL, TC8_CS_DIV1));
    wr(TC8_ADDR_COUNT, 8'h40);
    wr(TC8_ADDR_CTRL, ctl(TC8_COM_OFF, TC8_WGM_NORMAL, TC8_CS_STOP));
    rd(TC8_ADDR_COUNT, seen);
    chkr("count write", 8'h40, 8'h45, seen);
    // normal mode wrap sets overflow; mask gates the request
    wr(TC8_ADDR_FLAG, 8'h03);
    wr(TC8_ADDR_MASK, 8'h03);
    wr(TC8_ADDR_COUNT, 8'hfe);
    wr(TC8_ADDR_CTRL, ctl(TC8_COM_OFF, TC8_WGM_NORMAL, TC8_CS_DIV1));
    repeat (6) @(posedge clock);
    wr(TC8_ADDR_CTRL, ctl(TC8_COM_OFF, TC8_WGM_NORMAL, TC8_CS_STOP));
    rd(TC8_ADDR_COUNT, seen);
    chkr("wrapped count", 8'h00, 8'h0a, seen);
    rdchk(TC8_ADDR_FLAG, 8'h01, "overflow flag");
    chk1("ovf request", 1'b1, overflow_request);
    wr(TC8_ADDR_MASK, 8'h02);
    chk1("ovf masked", 1'b0, overflow_request);
    wr(TC8_ADDR_FLAG, 8'h01);
    rdchk(TC8_ADDR_FLAG, 8'h00, "flag cleared");
    // phase-correct mode turns at the top: no overflow on the way up,
    // but the climb passes the compare value of a5
    wr(TC8_ADDR_COUNT, 8'h00);
    wr(TC8_ADDR_CTRL, ctl(TC8_COM_OFF, TC8_WGM_PHASE, TC8_CS_DIV1));
    repeat (300) @(posedge clock);
    rdchk(TC8_ADDR_FLAG, 8'h02, "phase up flags");
    repeat (260) @(posedge clock);
    rd(TC8_ADDR_FLAG, seen);
    chk1("phase ovf", 1'b1, seen[TC8_BIT_OVF]);
    wr(TC8_ADDR_CTRL, ctl(TC8_COM_OFF, TC8_WGM_NORMAL, TC8_CS_STOP));
    wr(TC8_ADDR_FLAG, 8'h03);
    // ctc on pin rising edges, compare of 5, toggling output
    wr(TC8_ADDR_CMP, 8'h05);
    wr(TC8_ADDR_COUNT, 8'h00);
    wr(TC8_ADDR_CTRL, ctl(TC8_COM_TOGGLE, TC8_WGM_CTC, TC8_CS_EXT_RISE));
    pulse(5);
    rdchk(TC8_ADDR_COUNT, 8'h05, "ctc count");
    rdchk(TC8_ADDR_FLAG, 8'h00, "flag waits tick");
    chk1("cmp request low", 1'b0, compare_request);
    pulse(1);
    rdchk(TC8_ADDR_COUNT, 8'h00, "ctc clear");
    rdchk(TC8_ADDR_FLAG, 8'h02, "match flag");
    chk1("cmp request", 1'b1, compare_request);
    chk1("cmp pin toggled", 1'b1, compare_output_pin);
    // falling edges count too, one step each
    wr(TC8_ADDR_FLAG, 8'h03);
    wr(TC8_ADDR_CTRL, ctl(TC8_COM_OFF, TC8_WGM_NORMAL, TC8_CS_EXT_FALL));
    pulse(3);
    rdchk(TC8_ADDR_COUNT, 8'h03, "fall count");
    // counter write equal to compare blocks that match only
    wr(TC8_ADDR_CTRL, ctl(TC8_COM_OFF, TC8_WGM_NORMAL, TC8_CS_EXT_RISE));
    wr(TC8_ADDR_CMP, 8'h07);
    wr(TC8_ADDR_COUNT, 8'h07);
    pulse(1);
    rdchk(TC8_ADDR_FLAG, 8'h00, "match blocked");
    rdchk(TC8_ADDR_COUNT, 8'h08, "step after block");
    wr(TC8_ADDR_COUNT, 8'h06);
    pulse(2);
    rdchk(TC8_ADDR_FLAG, 8'h02, "match after block");
    // pwm mode: software sees its own buffer value
    wr(TC8_ADDR_CTRL, ctl(TC8_COM_CLEAR, TC8_WGM_FAST, TC8_CS_STOP));
    wr(TC8_ADDR_CMP, 8'h30);
    rdchk(TC8_ADDR_CMP, 8'h30, "buffered compare");
    // fast pwm run across the wrap: buffer loads at top, no match below 30
    wr(TC8_ADDR_FLAG, 8'h03);
    wr(TC8_ADDR_COUNT, 8'hfd);
    wr(TC8_ADDR_CTRL, ctl(TC8_COM_CLEAR, TC8_WGM_FAST, TC8_CS_DIV1));
    repeat (20) @(posedge clock);
    wr(TC8_ADDR_CTRL, ctl(TC8_COM_CLEAR, TC8_WGM_FAST, TC8_CS_STOP));
    rdchk(TC8_ADDR_FLAG, 8'h01, "fast pwm flags");
    chk1("fast pwm pin", 1'b1, compare_output_pin);
    rdchk(TC8_ADDR_COUNT, 8'h13, "fast pwm count");
    close_out();
  end

endmodule : tb
